//--- rtl/ssp_pkg.sv
`default_nettype none
package ssp_pkg;

   // ------------------------------------------------------------
   // register map, one byte per register, port picked by addr[3]
   // ------------------------------------------------------------
   localparam logic [2:0] REG_STATUS = 3'h0;
   localparam logic [2:0] REG_CTRL1  = 3'h1;
   localparam logic [2:0] REG_CTRL3  = 3'h2;
   localparam logic [2:0] REG_DATA   = 3'h3;
   localparam logic [2:0] REG_BAUD   = 3'h4;
   localparam logic [2:0] REG_EVENT  = 3'h5;
   localparam int         PORT_SEL_BIT = 3;
   localparam int         PORT_COUNT   = 2;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int ST_SMP  = 7;
   localparam int ST_CKE  = 6;
   localparam int ST_BF   = 0;
   localparam int C1_WRITE_COLLISION_FLAG = 7;
   localparam int C1_OVF  = 6;
   localparam int C1_EN   = 5;
   localparam int C1_CKP  = 4;
   localparam int C3_BOEN = 4;
   localparam int EV_IF   = 0;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_MODE = 4'h0;

   // ------------------------------------------------------------
   // port mode field codes
   // ------------------------------------------------------------
   localparam logic [3:0] MODE_HOST_DIV4  = 4'h0;
   localparam logic [3:0] MODE_HOST_DIV16 = 4'h1;
   localparam logic [3:0] MODE_HOST_DIV64 = 4'h2;
   localparam logic [3:0] MODE_HOST_TMR2  = 4'h3;
   localparam logic [3:0] MODE_CLIENT_SS  = 4'h4;
   localparam logic [3:0] MODE_CLIENT     = 4'h5;
   localparam logic [3:0] MODE_HOST_BAUD  = 4'ha;

   // ------------------------------------------------------------
   // timing: bit period divisors and half-period counts
   // ------------------------------------------------------------
   localparam int         DIV_W       = 10;
   localparam int         BITDIV_4    = 4;
   localparam int         BITDIV_16   = 16;
   localparam int         BITDIV_64   = 64;
   localparam logic [9:0] HALF_DIV4   = 10'(BITDIV_4 / 2);
   localparam logic [9:0] HALF_DIV16  = 10'(BITDIV_16 / 2);
   localparam logic [9:0] HALF_DIV64  = 10'(BITDIV_64 / 2);
   localparam int         BYTE_BITS   = 8;
   localparam logic [2:0] LAST_BIT    = 3'(BYTE_BITS - 1);
   localparam logic [4:0] HOST_EDGES  = 5'(2 * BYTE_BITS);

endpackage
`default_nettype wire

//--- rtl/ssp_spi_top.sv
// Notes on behaviour
// - eight-bit shift register, msb out first, new bit enters at lsb.
// - output changes on one serial-clock edge, input captured on the other.
// - host role drives the serial clock, client role takes it in.
// - full byte goes to data buffer, sets buffer-full and interrupt flag.
// - receive is double-buffered; next byte shifts while buffer waits.
// - transmit is unbuffered; data write loads shift register at once.
// - data write during a transfer is dropped and sets write-collision.
// - write-collision stays until software clears it; writes wait for that.
// - reading the data buffer clears buffer-full.
// - port works only while enabled; reconfigure with enable cleared.
// - status low six bits read-only, upper two read-write; control1 all rw.
// - control1 bits 5:0 and status 7:6 pick role, polarity, phase, rate.
// - clock polarity sets the idle level of the serial clock.
// - sample phase picks capture at middle or end of data output time.
// - one host rate uses the baud register as divider reload.
// - unselected client ignores clock and data and drives nothing.
// - shift register reached only through the data buffer.
// - two independent ports, each with its own registers and pins.
// - in host role a data write starts the exchange at once.
// - host rate is clock/4, /16, /64, timer2/2 or clock/(4*(baud+1)).
// - select released in select-controlled client mode stops driving data out.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// one serial port: registers, rate divider, shifter
// ---------------------------------------------------------------
module ssp_port
   import ssp_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   input  wire logic [2:0] i_reg,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rvalue,
   input  wire logic       i_tmr2_tick,
   input  wire logic       i_serial_clock_pin,
   output logic            o_serial_clock_pin,
   output logic            o_serial_clock_pin_oe_n,
   input  wire logic       i_serial_data_in_pin,
   output logic            o_serial_data_out_pin,
   output logic            o_serial_data_out_pin_oe_n,
   input  wire logic       i_client_select_pin_n,
   output logic            o_port_interrupt_flag
);
   import ssp_pkg::*;

   // ------------------------------------------------------------
   // software visible state
   // ------------------------------------------------------------
   logic       smp;
   logic       cke;
   logic       buffer_full_flag;
   logic       write_collision_flag;
   logic       overflow_flag;
   logic       port_enable_bit;
   logic       ckp;
   logic [3:0] mode;
   logic [7:0] port_control_reg_3;
   logic [7:0] port_data_buffer;
   logic [7:0] port_address_baud_reg;

   // ------------------------------------------------------------
   // transfer engine state
   // ------------------------------------------------------------
   logic [7:0]       port_shift_register;
   logic [2:0]       bit_count;
   logic             shifting;
   logic             pend;
   logic             host_busy;
   logic [4:0]       edge_count;
   logic [DIV_W-1:0] div_count;
   logic             sck_level;
   logic             sck_prev;

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   wire wr_status = i_wr & (i_reg == REG_STATUS);
   wire wr_ctrl1  = i_wr & (i_reg == REG_CTRL1);
   wire wr_ctrl3  = i_wr & (i_reg == REG_CTRL3);
   wire wr_data   = i_wr & (i_reg == REG_DATA);
   wire wr_baud   = i_wr & (i_reg == REG_BAUD);
   wire wr_event  = i_wr & (i_reg == REG_EVENT);
   wire rd_data   = i_rd & (i_reg == REG_DATA);

   // ------------------------------------------------------------
   // role decode
   // ------------------------------------------------------------
   // role from mode field
   wire is_host = (mode == MODE_HOST_DIV4) | (mode == MODE_HOST_DIV16)
                | (mode == MODE_HOST_DIV64) | (mode == MODE_HOST_TMR2)
                | (mode == MODE_HOST_BAUD);
   wire is_client_ss = (mode == MODE_CLIENT_SS);
   wire is_client    = is_client_ss | (mode == MODE_CLIENT);
   wire client_sel   = ~is_client_ss | ~i_client_select_pin_n;
   wire client_abort = is_client_ss & i_client_select_pin_n;
   wire port_on      = port_enable_bit & (is_host | (is_client & client_sel));

   // ------------------------------------------------------------
   // write acceptance and collision
   // ------------------------------------------------------------
   wire xfer_busy = host_busy | shifting | pend;
   wire collide   = wr_data & (xfer_busy | write_collision_flag);
   // write goes to buffer and shifter
   wire load      = wr_data & ~collide;
   wire host_go   = load & port_enable_bit & is_host;

   // ------------------------------------------------------------
   // host rate selection
   // ------------------------------------------------------------
   // baud register as reload
   wire [DIV_W-1:0] half_baud = {1'b0, port_address_baud_reg, 1'b0} + 10'h002;
   // rate choices, half period in system clocks
   wire [DIV_W-1:0] half_len = (mode == MODE_HOST_DIV16) ? HALF_DIV16
                             : (mode == MODE_HOST_DIV64) ? HALF_DIV64
                             : (mode == MODE_HOST_BAUD)  ? half_baud
                             : HALF_DIV4;
   wire             use_tmr2  = (mode == MODE_HOST_TMR2);
   // timer2 pulse is a half period, giving timer2/2 bit rate
   wire             host_tick = host_busy
                              & (use_tmr2 ? i_tmr2_tick : (div_count == '0));

   // ------------------------------------------------------------
   // clock edge classification
   // ------------------------------------------------------------
   wire host_edge  = host_tick & (edge_count != HOST_EDGES);
   wire host_end   = host_tick & (edge_count == HOST_EDGES);
   // leading edge leaves the idle level
   wire lead_host  = host_edge & (sck_level == ckp);
   wire trail_host = host_edge & (sck_level != ckp);
   wire client_run = port_enable_bit & is_client & client_sel;
   wire lead_cli   = client_run & (sck_prev == ckp) & (i_serial_clock_pin != ckp);
   wire trail_cli  = client_run & (sck_prev != ckp) & (i_serial_clock_pin == ckp);
   wire lead_ev    = lead_host | lead_cli;
   wire trail_ev   = trail_host | trail_cli;
   // drive on one edge, capture on the other
   wire cap_ev     = cke ? lead_ev  : trail_ev;
   wire drv_ev     = cke ? trail_ev : lead_ev;

   // ------------------------------------------------------------
   // shift control
   // ------------------------------------------------------------
   // late sampling only in host role
   wire smp_late  = smp & is_host;
   wire shift_now = (cap_ev & ~smp_late) | (pend & (drv_ev | host_end));
   // msb out, new bit in at lsb
   wire [7:0] rx_byte = {port_shift_register[6:0], i_serial_data_in_pin};
   wire byte_done = shift_now & (bit_count == LAST_BIT);
   // buffer loads unless unread, daisy-chain overrides
   wire buf_take  = byte_done & (~buffer_full_flag | port_control_reg_3[C3_BOEN]);
   wire next_sdo  = pend ? port_shift_register[6] : port_shift_register[7];
   // disable or select release resets counting
   wire restart   = ~port_enable_bit | client_abort;

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   // status upper bits and control1 writable
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         smp                   <= 1'b0;
         cke                   <= 1'b0;
         port_enable_bit       <= 1'b0;
         ckp                   <= 1'b0;
         mode                  <= RST_MODE;
         port_control_reg_3    <= RST_BYTE;
         port_address_baud_reg <= RST_BYTE;
      end
      else
      begin
         if (wr_status)
         begin
            smp <= i_wdata[ST_SMP];
            cke <= i_wdata[ST_CKE];
         end
         if (wr_ctrl1)
         begin
            port_enable_bit <= i_wdata[C1_EN];
            ckp             <= i_wdata[C1_CKP];
            mode            <= i_wdata[3:0];
         end
         if (wr_ctrl3)
            port_control_reg_3 <= i_wdata;
         if (wr_baud)
            port_address_baud_reg <= i_wdata;
      end
   end

   // ------------------------------------------------------------
   // sticky flags: hardware set beats software clear
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         buffer_full_flag      <= 1'b0;
         write_collision_flag  <= 1'b0;
         overflow_flag         <= 1'b0;
         o_port_interrupt_flag <= 1'b0;
      end
      else
      begin
         // set buffer-full on a stored byte
         if (buf_take)
            buffer_full_flag <= 1'b1;
         else if (rd_data)
            buffer_full_flag <= 1'b0;
         if (collide)
            write_collision_flag <= 1'b1;
         else if (wr_ctrl1)
            write_collision_flag <= i_wdata[C1_WRITE_COLLISION_FLAG];
         if (byte_done & ~buf_take)
            overflow_flag <= 1'b1;
         else if (wr_ctrl1)
            overflow_flag <= i_wdata[C1_OVF];
         if (byte_done)
            o_port_interrupt_flag <= 1'b1;
         else if (wr_event)
            o_port_interrupt_flag <= i_wdata[EV_IF];
      end
   end

   // ------------------------------------------------------------
   // data buffer and shift register
   // ------------------------------------------------------------
   // shifter only loads via the data write
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         port_data_buffer    <= RST_BYTE;
         port_shift_register <= RST_BYTE;
      end
      else
      begin
         if (load)
            port_data_buffer <= i_wdata;
         else if (buf_take)
            port_data_buffer <= rx_byte;
         // same write lands in the shifter
         if (load)
            port_shift_register <= i_wdata;
         else if (shift_now)
            port_shift_register <= rx_byte;
      end
   end

   // ------------------------------------------------------------
   // bit counter and deferred sample
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         bit_count <= 3'h0;
         shifting  <= 1'b0;
         pend      <= 1'b0;
      end
      else if (restart)
      begin
         bit_count <= 3'h0;
         shifting  <= 1'b0;
         pend      <= 1'b0;
      end
      else
      begin
         if (cap_ev & smp_late)
            pend <= 1'b1;
         else if (shift_now)
            pend <= 1'b0;
         if (shift_now)
         begin
            bit_count <= bit_count + 3'h1;
            shifting  <= ~byte_done;
         end
         else if (cap_ev | drv_ev)
            shifting <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // host clock generator
   // ------------------------------------------------------------
   // idle level always follows polarity between transfers
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         host_busy  <= 1'b0;
         edge_count <= 5'h00;
         div_count  <= '0;
         sck_level  <= 1'b0;
      end
      else if (~port_enable_bit)
      begin
         host_busy  <= 1'b0;
         edge_count <= 5'h00;
         sck_level  <= ckp;
      end
      else if (host_go)
      begin
         host_busy  <= 1'b1;
         edge_count <= 5'h00;
         div_count  <= half_len - 10'h001;
         sck_level  <= ckp;
      end
      else if (host_tick)
      begin
         div_count  <= half_len - 10'h001;
         edge_count <= edge_count + 5'h01;
         // clock stops after the last edge
         if (host_end)
            host_busy <= 1'b0;
         else
            sck_level <= ~sck_level;
      end
      else
      begin
         if (host_busy)
            div_count <= div_count - 10'h001;
         if (~host_busy)
            sck_level <= ckp;
      end
   end

   // ------------------------------------------------------------
   // pin drivers, all registered
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sck_prev                   <= 1'b0;
         o_serial_clock_pin         <= 1'b0;
         o_serial_clock_pin_oe_n    <= 1'b1;
         o_serial_data_out_pin      <= 1'b0;
         o_serial_data_out_pin_oe_n <= 1'b1;
      end
      else
      begin
         sck_prev <= i_serial_clock_pin;
         // clock driven only in host role
         o_serial_clock_pin      <= sck_level;
         o_serial_clock_pin_oe_n <= ~(port_enable_bit & is_host);
         // data changes on the drive edge
         if (load & cke)
            o_serial_data_out_pin <= i_wdata[7];
         else if (drv_ev)
            o_serial_data_out_pin <= next_sdo;
         o_serial_data_out_pin_oe_n <= ~port_on;
      end
   end

   // ------------------------------------------------------------
   // read mux, registered by the top
   // ------------------------------------------------------------
   // status low bits are hardware only
   always_comb
   begin
      case (i_reg)
         REG_STATUS: o_rvalue = {smp, cke, 5'h00, buffer_full_flag};
         REG_CTRL1:  o_rvalue = {write_collision_flag, overflow_flag,
                                 port_enable_bit, ckp, mode};
         REG_CTRL3:  o_rvalue = port_control_reg_3;
         REG_DATA:   o_rvalue = port_data_buffer;
         REG_BAUD:   o_rvalue = port_address_baud_reg;
         REG_EVENT:  o_rvalue = {7'h00, o_port_interrupt_flag};
         default:    o_rvalue = 8'h00;
      endcase
   end

endmodule

// ---------------------------------------------------------------
// top: two independent ports on one register port
// ---------------------------------------------------------------
module ssp_spi_top
   import ssp_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire logic [1:0] i_tmr2_tick,
   input  wire logic [1:0] i_serial_clock_pin,
   output logic      [1:0] o_serial_clock_pin,
   output logic      [1:0] o_serial_clock_pin_oe_n,
   input  wire logic [1:0] i_serial_data_in_pin,
   output logic      [1:0] o_serial_data_out_pin,
   output logic      [1:0] o_serial_data_out_pin_oe_n,
   input  wire logic [1:0] i_client_select_pin_n,
   output logic      [1:0] o_port_interrupt_flag
);
   import ssp_pkg::*;

   // ------------------------------------------------------------
   // port select
   // ------------------------------------------------------------
   wire       port_sel = i_addr[PORT_SEL_BIT];
   wire [7:0] rvalue [PORT_COUNT];

   // ------------------------------------------------------------
   // per-port instances
   // ------------------------------------------------------------
   // two ports, fully separate state
   genvar g;
   generate
      for (g = 0; g < PORT_COUNT; g = g + 1)
      begin : g_port
         wire hit = (port_sel == 1'(g));
         ssp_port u_port (
            .i_mclk                     (i_mclk),
            .i_rst                      (i_rst),
            .i_reg                      (i_addr[2:0]),
            .i_wdata                    (i_wdata),
            .i_wr                       (i_wr & hit),
            .i_rd                       (i_rd & hit),
            .o_rvalue                   (rvalue[g]),
            .i_tmr2_tick                (i_tmr2_tick[g]),
            .i_serial_clock_pin         (i_serial_clock_pin[g]),
            .o_serial_clock_pin         (o_serial_clock_pin[g]),
            .o_serial_clock_pin_oe_n    (o_serial_clock_pin_oe_n[g]),
            .i_serial_data_in_pin       (i_serial_data_in_pin[g]),
            .o_serial_data_out_pin      (o_serial_data_out_pin[g]),
            .o_serial_data_out_pin_oe_n (o_serial_data_out_pin_oe_n[g]),
            .i_client_select_pin_n      (i_client_select_pin_n[g]),
            .o_port_interrupt_flag      (o_port_interrupt_flag[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // read data, valid only the cycle after the read strobe
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         o_rdata <= 8'h00;
      else if (i_rd)
         o_rdata <= rvalue[port_sel];
      else
         o_rdata <= 8'h00;
   end

endmodule
`default_nettype wire

//--- tb/ssp_spi_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port-level checks for the two-port block
// ----------------------------------------
module ssp_spi_top_properties
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   input  wire logic [3:0] i_addr,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] o_rdata,
   input  wire logic [1:0] o_serial_clock_pin,
   input  wire logic [1:0] o_serial_clock_pin_oe_n,
   input  wire logic [1:0] o_serial_data_out_pin_oe_n,
   input  wire logic [1:0] i_client_select_pin_n,
   input  wire logic [1:0] o_port_interrupt_flag
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   AST_RDATA_ONE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside its cycle");
   AST_STATUS_RO: assert property (i_rd && i_addr[2:0] == 3'h0 |=> o_rdata[5:1] == 5'h00)
      else $error("status middle bits not zero");
   AST_EVENT_RD: assert property (i_rd && i_addr == 4'h5
      |=> o_rdata[0] == $past(o_port_interrupt_flag[0]))
      else $error("event read differs from flag");
   AST_IRQ_STICKY: assert property (o_port_interrupt_flag[0] && !(i_wr && i_addr == 4'h5)
      |=> o_port_interrupt_flag[0])
      else $error("flag dropped without clear");
   AST_IRQ_PORTS: assert property (o_port_interrupt_flag[1] && !(i_wr && i_addr == 4'hd)
      |=> o_port_interrupt_flag[1])
      else $error("port 1 flag lost");
   AST_IRQ_HOST: assert property ($rose(o_port_interrupt_flag[0])
      |-> !o_serial_clock_pin_oe_n[0])
      else $error("flag rose with clock released");
   AST_SCK_HALF: assert property (!o_serial_clock_pin_oe_n[0] && $changed(o_serial_clock_pin[0])
      |=> $stable(o_serial_clock_pin[0]))
      else $error("serial clock half period too short");
   // port 1 runs only in select mode here
   AST_SDO_REL: assert property (i_client_select_pin_n[1] && $past(i_client_select_pin_n[1])
      |-> o_serial_data_out_pin_oe_n[1])
      else $error("unselected client drives data");
endmodule
bind ssp_spi_top ssp_spi_top_properties ssp_spi_top_properties_i (.i_mclk, .i_rst, .i_addr,
   .i_wr, .i_rd, .o_rdata, .o_serial_clock_pin, .o_serial_clock_pin_oe_n,
   .o_serial_data_out_pin_oe_n, .i_client_select_pin_n, .o_port_interrupt_flag);
`default_nettype wire

//--- tb/ssp_client_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// spi client facing host port 0
// ------------------------------
module ssp_client_model
(
   input  wire logic       i_sck,
   input  wire logic       i_mosi,
   input  wire logic       i_sel_n,
   input  wire logic [7:0] i_tx,
   output logic            o_miso,
   output logic      [7:0] o_rx
);
   logic [7:0] sr = 8'h00;
   // released line shows the inverse, never a stale bit
   assign o_miso = i_sel_n ? ~sr[7] : sr[7];
   // msb ready before the first edge
   always @(negedge i_sel_n) sr = i_tx;
   // capture on rising, shift on falling
   always @(posedge i_sck) if (!i_sel_n) o_rx = {o_rx[6:0], i_mosi};
   always @(negedge i_sck) if (!i_sel_n) sr = {sr[6:0], 1'b0};
endmodule
`default_nettype wire

//--- tb/test_ssp_spi_top.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------
// port 0 host to model, port 1 client on its wires
// ----------------------------------------------
module test_ssp_spi_top;
   import ssp_pkg::*;
   logic       i_mclk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, sel_n = 1'b1, miso;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00, o_rdata, rx;
   logic [1:0] sck, sck_oe_n, sdo, sdo_oe_n, irq;
   logic [1:0] tmr_tick = 2'b00;
   int         err_count = 0, samples_checked = 0;
   always #5 i_mclk = ~i_mclk;
   // timer2 pulse every other cycle, a half period each
   always @(posedge i_mclk) tmr_tick <= ~tmr_tick;
   ssp_spi_top ssp_spi_top_i (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_tmr2_tick(tmr_tick), .i_serial_clock_pin({sck[0], 1'b0}), .o_serial_clock_pin(sck),
      .o_serial_clock_pin_oe_n(sck_oe_n), .i_serial_data_in_pin({sdo[0], miso}),
      .o_serial_data_out_pin(sdo), .o_serial_data_out_pin_oe_n(sdo_oe_n),
      .i_client_select_pin_n({sel_n, 1'b1}), .o_port_interrupt_flag(irq));
   ssp_client_model ssp_client_model_i (.i_sck(sck[0]), .i_mosi(sdo[0]), .i_sel_n(sel_n),
      .i_tx(8'h3c), .o_miso(miso), .o_rx(rx));
   task wrap_up;
      if (err_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e)
      begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // one-cycle strobes, settled sample after the edge
   task wr(input logic [3:0] a, input logic [7:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      #1;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, e);
   endtask
   // bounded wait, a timeout ends the run
   task wait_irq(input int p);
      int n;
      // settled look, one step after each edge
      for (n = 0; n < 300 && irq[p] !== 1'b1; n++)
      begin
         @(posedge i_mclk);
         #1;
      end
      chk(irq[p], 1'b1);
      if (irq[p] !== 1'b1) wrap_up();
   endtask
   initial
   begin
      repeat (4) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      #1 chk(sck_oe_n, 2'b11);
      rd(4'h1, 8'h00);
      wr(4'h0, 8'h7f);
      rd(4'h0, 8'h40);
      wr(4'h8, 8'h40);
      wr(4'h9, 8'h24);
      wr(4'h1, 8'h20);
      sel_n <= 1'b0;
      wr(4'h3, 8'ha5);
      chk(sck_oe_n, 2'b10);
      chk(sdo_oe_n, 2'b00);
      wr(4'h3, 8'h11);
      wait_irq(0);
      wait_irq(1);
      repeat (4) @(posedge i_mclk);
      sel_n <= 1'b1;
      rd(4'h5, 8'h01);
      rd(4'h0, 8'h41);
      rd(4'h3, 8'h3c);
      rd(4'h0, 8'h40);
      rd(4'h1, 8'ha0);
      rd(4'hb, 8'ha5);
      chk(rx, 8'ha5);
      chk(sdo_oe_n[1], 1'b1);
      wr(4'h3, 8'h5a);
      rd(4'h3, 8'h3c);
      wr(4'h1, 8'h20);
      rd(4'h1, 8'h20);
      wr(4'h5, 8'h00);
      chk(irq, 2'b10);
      rd(4'h6, 8'h00);
      wr(4'h1, 8'h03);
      wr(4'h1, 8'h23);
      sel_n <= 1'b0;
      wr(4'h3, 8'hc3);
      wait_irq(0);
      repeat (4) @(posedge i_mclk);
      sel_n <= 1'b1;
      rd(4'h3, 8'h3c);
      chk(rx, 8'hc3);
      wr(4'h1, 8'h10);
      wr(4'h1, 8'h30);
      repeat (2) @(posedge i_mclk);
      #1 chk(sck[0], 1'b1);
      wr(4'h1, 8'h10);
      repeat (2) @(posedge i_mclk);
      #1 chk(sck_oe_n[0], 1'b1);
      chk(sdo_oe_n, 2'b11);
      wrap_up();
   end
endmodule
`default_nettype wire
